// *** rtl/event_counter_bank.sv ***
`timescale 1ns/1ps
// bank of bcd event counters: up, stage and up/down modes
module event_counter_bank #(
   parameter int unsigned N = counter_pkg::NUM_COUNTERS
) (
   input  wire logic                                   clk,
   input  wire logic                                   rst_n,
   input  wire counter_pkg::counter_mode_e [N-1:0]     mode,
   input  wire counter_pkg::counter_in_s   [N-1:0]     ctl_in,
   input  wire counter_pkg::preset_s       [N-1:0]     preset,
   input  wire logic [counter_pkg::WORD_ADDR_W-1:0]    rd_addr,
   output logic [counter_pkg::BCD8_W-1:0]              rd_data,
   output logic                                        rd_hit,
   output logic [N-1:0]                                counter_done_flag,
   output logic [N-1:0][counter_pkg::BCD8_W-1:0]       count_value
);
   // refuse bank sizes outside 1 to 128 counters
   if (N < 1 || N > 128) begin : g_bad_size
      $error("counter bank size out of range");
   end

   logic [N-1:0]                          up_prev_r, up_prev_nxt;
   logic [N-1:0]                          dn_prev_r, dn_prev_nxt;
   logic [N-1:0][counter_pkg::BCD8_W-1:0] val_r, val_nxt;
   logic [N-1:0]                          done_r, done_nxt;
   logic [counter_pkg::BCD8_W-1:0]        rd_data_r, rd_data_nxt;
   logic                                  rd_hit_r, rd_hit_nxt;
   logic [N-1:0][counter_pkg::BCD8_W-1:0] step_res;
   logic [N-1:0][counter_pkg::BCD8_W-1:0] ceil_v;
   logic [N-1:0]                          step_down;

   // ceiling per mode, up and stage use four digits
   function automatic logic [counter_pkg::BCD8_W-1:0] ceiling_of(counter_pkg::counter_mode_e m);
      if (m == counter_pkg::MODE_UPDN) begin
         return counter_pkg::CEIL8;
      end
      return {16'h0000, counter_pkg::CEIL4};
   endfunction : ceiling_of

   // effective preset, trimmed to four digits outside up/down mode
   function automatic logic [counter_pkg::BCD8_W-1:0] preset_of(counter_pkg::preset_s p,
                                                                counter_pkg::counter_mode_e m);
      logic [counter_pkg::BCD8_W-1:0] v;
      v = p.use_word ? p.word_val : p.const_val;
      if (m != counter_pkg::MODE_UPDN) begin
         v = {16'h0000, v[counter_pkg::BCD4_W-1:0]};
      end
      return v;
   endfunction : preset_of

   // one step unit per counter
   for (genvar g = 0; g < N; g++) begin : g_step
      assign ceil_v[g] = ceiling_of(mode[g]);
      bcd_step u_step (
         .value   (val_r[g]),
         .down    (step_down[g]),
         .ceiling (ceil_v[g]),
         .result  (step_res[g])
      );
   end

   // down-step select, kept apart so the step units see no loop through the next-value process
   always_comb begin
      for (int i = 0; i < N; i++) begin
         step_down[i] = (mode[i] == counter_pkg::MODE_UPDN) && ctl_in[i].count_down &&
                        !dn_prev_r[i] && !ctl_in[i].count_up;
      end
   end

   // next value, edge memory and done flag for each counter
   always_comb begin
      logic rise_up;
      logic clr;
      logic [counter_pkg::BCD8_W-1:0] v;
      rise_up = 1'b0;
      clr     = 1'b0;
      v       = '0;
      for (int i = 0; i < N; i++) begin
         up_prev_nxt[i] = ctl_in[i].count_up;
         dn_prev_nxt[i] = ctl_in[i].count_down;
         rise_up = ctl_in[i].count_up & ~up_prev_r[i];
         v = val_r[i];
         unique case (mode[i])
            counter_pkg::MODE_UP: begin
               clr = ctl_in[i].reset_in;
               if (rise_up) v = step_res[i];
            end
            counter_pkg::MODE_STAGE: begin
               clr = ctl_in[i].clear_cmd;
               if (rise_up) v = step_res[i];
            end
            counter_pkg::MODE_UPDN: begin
               clr = ctl_in[i].reset_in;
               // both inputs on: neither counts
               if (rise_up && !ctl_in[i].count_down) begin
                  v = step_res[i];
               end else if (step_down[i]) begin
                  v = step_res[i];
               end
            end
            default: begin
               clr = 1'b1;
            end
         endcase
         if (clr) v = counter_pkg::ZERO8;
         val_nxt[i]  = v;
         done_nxt[i] = (v >= preset_of(preset[i], mode[i])) && !clr;
      end
   end

   // counter state registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         up_prev_r <= '0;
         dn_prev_r <= '0;
         val_r     <= '0;
         done_r    <= '0;
      end else begin
         up_prev_r <= up_prev_nxt;
         dn_prev_r <= dn_prev_nxt;
         val_r     <= val_nxt;
         done_r    <= done_nxt;
      end
   end

   // word-memory read port at counter index plus base
   always_comb begin
      logic [counter_pkg::WORD_ADDR_W-1:0] idx;
      idx         = rd_addr - counter_pkg::WORD_ADDR_W'(counter_pkg::WORD_BASE);
      rd_hit_nxt  = (rd_addr >= counter_pkg::WORD_ADDR_W'(counter_pkg::WORD_BASE)) &&
                    (idx < counter_pkg::WORD_ADDR_W'(N));
      rd_data_nxt = '0;
      for (int i = 0; i < N; i++) begin
         if (rd_hit_nxt && idx == counter_pkg::WORD_ADDR_W'(i)) rd_data_nxt = val_r[i];
      end
   end

   // read port registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data_r <= '0;
         rd_hit_r  <= 1'b0;
      end else begin
         rd_data_r <= rd_data_nxt;
         rd_hit_r  <= rd_hit_nxt;
      end
   end

   assign rd_data           = rd_data_r;
   assign rd_hit            = rd_hit_r;
   assign counter_done_flag = done_r;
   assign count_value       = val_r;

   // checks on every counter of the bank
   for (genvar g = 0; g < N; g++) begin : g_chk
      a_reset_zeroes: assert property (@(posedge clk) disable iff (!rst_n)
         (mode[g] != counter_pkg::MODE_STAGE && ctl_in[g].reset_in) |=>
         (val_r[g] == '0 && !done_r[g]))
         else $error("reset did not zero counter");
      a_clear_stage: assert property (@(posedge clk) disable iff (!rst_n)
         (mode[g] == counter_pkg::MODE_STAGE && ctl_in[g].clear_cmd) |=>
         (val_r[g] == '0 && !done_r[g]))
         else $error("clear did not zero stage counter");
      a_stage_noreset: assert property (@(posedge clk) disable iff (!rst_n)
         (mode[g] == counter_pkg::MODE_STAGE && $stable(mode[g]) && !ctl_in[g].clear_cmd &&
          !(ctl_in[g].count_up && !up_prev_r[g])) |=> $stable(val_r[g]))
         else $error("stage counter changed without edge");
      a_no_level_count: assert property (@(posedge clk) disable iff (!rst_n)
         (mode[g] == counter_pkg::MODE_UP && $stable(mode[g]) && ctl_in[g].count_up && up_prev_r[g] &&
          !ctl_in[g].reset_in) |=> $stable(val_r[g]))
         else $error("counted on a steady level");
      a_up_edge: assert property (@(posedge clk) disable iff (!rst_n)
         (mode[g] == counter_pkg::MODE_UP && !ctl_in[g].reset_in && ctl_in[g].count_up && !up_prev_r[g] &&
          val_r[g] == 32'h0000_0009) |=> (val_r[g] == 32'h0000_0010))
         else $error("bcd increment wrong");
      a_ceiling_hold: assert property (@(posedge clk) disable iff (!rst_n)
         (mode[g] == counter_pkg::MODE_UP && $stable(mode[g]) && val_r[g] == {16'h0000, counter_pkg::CEIL4} &&
          !ctl_in[g].reset_in) |=> (val_r[g] == {16'h0000, counter_pkg::CEIL4}))
         else $error("ceiling not held");
      a_done_tracks: assert property (@(posedge clk) disable iff (!rst_n)
         ($past(rst_n) && !$past(ctl_in[g].reset_in) && !$past(ctl_in[g].clear_cmd) &&
          ($past(mode[g]) inside {counter_pkg::MODE_UP, counter_pkg::MODE_STAGE, counter_pkg::MODE_UPDN})) |->
         (done_r[g] == (val_r[g] >= preset_of($past(preset[g]), $past(mode[g])))))
         else $error("done flag disagrees with value");
      a_word_read: assert property (@(posedge clk) disable iff (!rst_n)
         (rd_addr == counter_pkg::WORD_ADDR_W'(counter_pkg::WORD_BASE + g)) |=>
         (rd_hit && rd_data == $past(val_r[g])))
         else $error("word read mismatch");
      a_updn_both: assert property (@(posedge clk) disable iff (!rst_n)
         (mode[g] == counter_pkg::MODE_UPDN && $stable(mode[g]) && ctl_in[g].count_up && ctl_in[g].count_down &&
          !ctl_in[g].reset_in) |=> $stable(val_r[g]))
         else $error("up/down counted with both inputs on");

      c_done_up: cover property (@(posedge clk) mode[g] == counter_pkg::MODE_UP && $rose(done_r[g]));
      c_stage_clear: cover property (@(posedge clk) mode[g] == counter_pkg::MODE_STAGE && done_r[g] ##1 !done_r[g]);
      c_updn_down: cover property (@(posedge clk) mode[g] == counter_pkg::MODE_UPDN && step_down[g]);
      c_ceiling: cover property (@(posedge clk) val_r[g] == {16'h0000, counter_pkg::CEIL4});
   end
endmodule : event_counter_bank

// *** shared/counter_pkg.sv ***
// package: constants and carriers for the event counter bank
package counter_pkg;
   localparam int unsigned NUM_COUNTERS    = 8;
   localparam int unsigned BCD4_W          = 16;
   localparam int unsigned BCD8_W          = 32;
   localparam int unsigned WORD_BASE       = 1000;
   localparam int unsigned WORD_ADDR_W     = 11;
   localparam logic [3:0]  DIGIT_MAX       = 4'h9;
   localparam logic [BCD4_W-1:0] CEIL4     = 16'h9999;
   localparam logic [BCD8_W-1:0] CEIL8     = 32'h9999_9999;
   localparam logic [BCD8_W-1:0] ZERO8     = 32'h0000_0000;

   typedef enum logic [1:0] {
      MODE_UP    = 2'b00,
      MODE_STAGE = 2'b01,
      MODE_UPDN  = 2'b10
   } counter_mode_e;

   // per-counter inputs from the control program
   typedef struct packed {
      logic count_up;
      logic count_down;
      logic reset_in;
      logic clear_cmd;
   } counter_in_s;

   // preset selection: constant or word-memory value
   typedef struct packed {
      logic              use_word;
      logic [BCD8_W-1:0] const_val;
      logic [BCD8_W-1:0] word_val;
   } preset_s;
endpackage : counter_pkg

// *** rtl/bcd_step.sv ***
`timescale 1ns/1ps
// bcd increment/decrement of an eight-digit value with a ceiling
module bcd_step (
   input  wire logic [31:0] value,
   input  wire logic        down,
   input  wire logic [31:0] ceiling,
   output logic      [31:0] result
);
   // digit-wise add or subtract one, saturating at ceiling and zero
   always_comb begin
      logic carry;
      carry  = 1'b1;
      result = value;
      if (!down && value >= ceiling) begin
         result = ceiling;
      end else if (down && value == counter_pkg::ZERO8) begin
         result = value;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (carry) begin
               if (!down) begin
                  if (value[i*4 +: 4] == counter_pkg::DIGIT_MAX) begin
                     result[i*4 +: 4] = 4'h0;
                  end else begin
                     result[i*4 +: 4] = value[i*4 +: 4] + 4'h1;
                     carry = 1'b0;
                  end
               end else begin
                  if (value[i*4 +: 4] == 4'h0) begin
                     result[i*4 +: 4] = counter_pkg::DIGIT_MAX;
                  end else begin
                     result[i*4 +: 4] = value[i*4 +: 4] - 4'h1;
                     carry = 1'b0;
                  end
               end
            end
         end
      end
   end
endmodule : bcd_step

// *** bench/ctl_model.sv ***
`timescale 1ns/1ps
// control program model: drives the count, reset and clear levels
module ctl_model #(
   parameter int unsigned N = 4
) (
   input  wire logic                          clk,
   input  wire logic                          go,
   input  wire logic [1:0]                    sel,
   input  wire logic [3:0]                    which,
   output counter_pkg::counter_in_s [N-1:0]   ctl_r
);
   counter_pkg::counter_in_s [N-1:0] ctl_nxt;
   // request held while go is high, then all low so the next request is a fresh edge
   always_comb begin
      ctl_nxt = '0;
      if (go) begin
         ctl_nxt[sel] = which;
      end
   end
   always_ff @(posedge clk) begin
      ctl_r <= ctl_nxt;
   end
endmodule : ctl_model

// *** bench/tb.sv ***
`timescale 1ns/1ps
// bench: table-driven checks of the event counter bank
module tb;
   localparam int unsigned N = 4;
   typedef struct packed {
      logic [1:0]  sel;
      logic [3:0]  which;
      logic [31:0] val;
      logic        done;
   } row_s;
   logic                               clk = 1'h0;
   logic                               rst_n = 1'h0;
   logic                               go = 1'h0;
   logic [1:0]                         sel = 2'h0;
   logic [3:0]                         which = 4'h0;
   logic [10:0]                        rd_addr = 11'h000;
   counter_pkg::counter_mode_e [N-1:0] mode;
   counter_pkg::counter_in_s   [N-1:0] ctl_in;
   counter_pkg::preset_s       [N-1:0] preset;
   logic [31:0]                        rd_data;
   logic                               rd_hit;
   logic [N-1:0]                       flags;
   logic [N-1:0][31:0]                 value;
   logic [31:0]                        d;
   logic                               h;
   int                                 mismatches = 0;
   int                                 samples_checked = 0;
   // which: 8 up, 4 down, 2 reset, 1 clear
   row_s rows [19] = '{
      '{2'h0,4'h8,32'h1,1'h0}, '{2'h0,4'h8,32'h2,1'h1}, '{2'h0,4'h8,32'h3,1'h1},
      '{2'h0,4'h2,32'h0,1'h0}, '{2'h0,4'ha,32'h0,1'h0}, '{2'h0,4'h8,32'h1,1'h0},
      '{2'h0,4'h1,32'h1,1'h0}, '{2'h1,4'h8,32'h1,1'h0}, '{2'h1,4'h8,32'h2,1'h1},
      '{2'h1,4'h2,32'h2,1'h1}, '{2'h1,4'h8,32'h3,1'h1}, '{2'h1,4'h1,32'h0,1'h0},
      '{2'h2,4'h8,32'h1,1'h0}, '{2'h2,4'h8,32'h2,1'h1}, '{2'h2,4'h4,32'h1,1'h0},
      '{2'h2,4'hc,32'h1,1'h0}, '{2'h2,4'h2,32'h0,1'h0}, '{2'h2,4'h4,32'h0,1'h0},
      '{2'h3,4'h8,32'h1,1'h1}};

   always #4 clk = ~clk;

   ctl_model #(.N(N)) model (.clk(clk), .go(go), .sel(sel), .which(which), .ctl_r(ctl_in));

   event_counter_bank #(.N(N)) dut (.clk(clk), .rst_n(rst_n), .mode(mode), .ctl_in(ctl_in),
      .preset(preset), .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit),
      .counter_done_flag(flags), .count_value(value));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one request, then two low cycles, then the answer has landed
   task automatic pulse(input logic [1:0] s, input logic [3:0] w);
      @(posedge clk) #1;
      go = 1'h1;
      sel = s;
      which = w;
      @(posedge clk) #1;
      go = 1'h0;
      repeat (2) @(posedge clk);
      #1;
   endtask : pulse

   task automatic rd(input logic [10:0] a);
      rd_addr = a;
      @(posedge clk) #1;
      d = rd_data;
      h = rd_hit;
   endtask : rd

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // hang guard
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end

   initial begin
      mode[0] = counter_pkg::MODE_UP;
      mode[1] = counter_pkg::MODE_STAGE;
      mode[2] = counter_pkg::MODE_UPDN;
      mode[3] = counter_pkg::MODE_UP;
      preset[0] = '{1'h0, 32'h2, 32'h0};
      preset[1] = '{1'h0, 32'h2, 32'h0};
      preset[2] = '{1'h0, 32'h2, 32'h0};
      preset[3] = '{1'h1, 32'h5, 32'h1};
      repeat (3) @(posedge clk);
      #1;
      chk(value[0] | value[3], 32'h0);
      chk({28'h0, flags}, 32'h0);
      rst_n = 1'h1;
      // ordinary cases from the table
      for (int i = 0; i < 19; i++) begin
         pulse(rows[i].sel, rows[i].which);
         chk(value[rows[i].sel], rows[i].val);
         chk({31'h0, flags[rows[i].sel]}, {31'h0, rows[i].done});
         rd(11'h3e8 + {9'h0, rows[i].sel});
         chk(d, rows[i].val);
         chk({31'h0, h}, 32'h1);
      end
      // preset edited while running
      preset[0].const_val = 32'h1;
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, flags[0]}, 32'h1);
      pulse(2'h0, 4'h8);
      chk(value[0], 32'h2);
      // a held count input counts once
      @(posedge clk) #1;
      go = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      go = 1'h0;
      repeat (2) @(posedge clk);
      #1;
      chk(value[0], 32'h3);
      // bcd carry and ceiling hold
      pulse(2'h0, 4'h2);
      for (int i = 1; i <= 10000; i++) begin
         pulse(2'h0, 4'h8);
         if (i == 10) begin
            chk(value[0], 32'h10);
         end
      end
      chk(value[0], 32'h9999);
      chk({31'h0, flags[0]}, 32'h1);
      pulse(2'h0, 4'h2);
      chk(value[0], 32'h0);
      // reads outside the counter range
      rd(11'h3ec);
      chk(d, 32'h0);
      chk({31'h0, h}, 32'h0);
      rd(11'h3e7);
      chk(d, 32'h0);
      chk({31'h0, h}, 32'h0);
      // second reset in mid-run
      rst_n = 1'h0;
      @(posedge clk) #1;
      chk(value[3], 32'h0);
      chk({28'h0, flags}, 32'h0);
      rst_n = 1'h1;
      pulse(2'h3, 4'h8);
      chk(value[3], 32'h1);
      chk({31'h0, flags[3]}, 32'h1);
      // illegal mode code holds the counter clear
      mode[3] = counter_pkg::counter_mode_e'(2'h3);
      pulse(2'h3, 4'h8);
      chk(value[3], 32'h0);
      chk({31'h0, flags[3]}, 32'h0);
      report_and_stop();
   end
endmodule : tb
